// File: hdl/sidp_datapath.sv
// Subtract instruction datapath: register subtract and pointer subtract.
// Assumes the core offers one instruction per cycle on instr_valid in decode phase
// and that the data memory returns read data combinationally while mem_req.rd is high, in the process phase.
`timescale 1ns/1ps
`default_nettype none
module sidp_datapath
    import sidp_pkg::*;
(
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 reset,
    // Instruction in
    input  wire logic                 instr_valid,
    input  wire logic [15:0]          instr,
    input  wire logic                 ext_set_en,
    input  wire logic [BANK_W-1:0]    bank_select_register,
    // Data memory
    output sidp_mem_req_t             mem_req,
    input  wire logic [DATA_W-1:0]    mem_rdata,
    // Architectural state
    output logic [DATA_W-1:0]         accumulator,
    output sidp_flags_t               flags,
    output logic [3*PTR_W-1:0]        indirect_address_pointer,
    output logic                      busy
);

    // Phase sequencer and held instruction word
    sidp_phase_t                phase_r, phase_nxt;
    logic [INSTR_W-1:0]         ir_r, ir_nxt;
    logic                       act_r, act_nxt;
    // Operand latch, accumulator and status flags
    logic [DATA_W-1:0]          opnd_r, opnd_nxt;
    logic [DATA_W-1:0]          acc_r, acc_nxt;
    sidp_flags_t                flg_r, flg_nxt;
    // Pointer bank
    logic [PTR_W-1:0]           ptr_r [PTR_NUM];
    logic [PTR_W-1:0]           ptr_nxt [PTR_NUM];
    // Registered data-memory request
    sidp_mem_req_t              req_r, req_nxt;
    // Decoded fields of the held instruction
    logic                       is_reg;
    logic                       is_ptr;
    logic                       to_reg;
    logic                       use_bank;
    logic                       indexed;
    logic                       ptr_ok;
    logic [PSEL_MSB-PSEL_LSB:0] psel;
    logic [FILE_W-1:0]          fadr;
    logic [LIT_W-1:0]           lit;
    // Address and arithmetic results
    logic [ADDR_W-1:0]          ea;
    logic [DATA_W:0]            diff;
    logic [NIB_W:0]             ldiff;
    logic [DATA_W-1:0]          res;
    sidp_flags_t                sub_flags;

    // Decode of the held instruction; the word is stable for the whole cycle
    always_comb begin
        is_reg   = ir_r[SUBREG_MSB:SUBREG_LSB] == SUBREG_OP; // RQ1
        is_ptr   = ir_r[SUBPTR_MSB:SUBPTR_LSB] == SUBPTR_OP; // RQ6
        to_reg   = ir_r[DEST_BIT]; // RQ2
        use_bank = ir_r[ACCESS_BIT]; // RQ3
        fadr     = ir_r[FILE_W-1:0];
        lit      = ir_r[LIT_W-1:0];
        psel     = ir_r[PSEL_MSB:PSEL_LSB];
        // Select code 3 belongs to another instruction, so it is refused here
        ptr_ok   = psel <= PSEL_MAX; // RQ6
        indexed  = ext_set_en && !use_bank && (fadr <= INDEXED_MAX); // RQ4
    end

    // Effective address of the register operand
    // Indexed form wraps inside the data space rather than faulting
    always_comb begin
        if (indexed) begin
            ea = ptr_r[PTR_INDEXED] + {{(ADDR_W-FILE_W){1'b0}}, fadr}; // RQ4
        end else if (use_bank) begin
            ea = {bank_select_register, fadr}; // RQ3
        end else if (fadr < ACCESS_SPLIT) begin
            ea = {{BANK_W{1'b0}}, fadr}; // RQ3
        end else begin
            ea = {ACCESS_HIBANK, fadr}; // RQ3
        end
    end

    // Register minus accumulator; carry out of the wide sum is not-borrow
    always_comb begin
        diff  = {1'b0, opnd_r} + {1'b0, ~acc_r} + {{DATA_W{1'b0}}, 1'b1}; // RQ1
        ldiff = {1'b0, opnd_r[NIB_W-1:0]} + {1'b0, ~acc_r[NIB_W-1:0]}
              + {{NIB_W{1'b0}}, 1'b1};
        res   = diff[DATA_W-1:0];
        // Flags come from the same sum, except digit carry, which uses a second low-nibble adder
        sub_flags.carry            = diff[DATA_W]; // RQ7
        sub_flags.digit_carry_flag = ldiff[NIB_W]; // RQ7
        sub_flags.zero             = res == '0; // RQ7
        sub_flags.negative         = res[DATA_W-1]; // RQ7
        sub_flags.overflow_flag    = (opnd_r[DATA_W-1] != acc_r[DATA_W-1])
                                   && (res[DATA_W-1] != opnd_r[DATA_W-1]); // RQ7
    end

    // Phase sequencer: one instruction takes exactly four clocks
    always_comb begin
        phase_nxt = phase_r;
        ir_nxt    = ir_r;
        act_nxt   = act_r;
        unique case (phase_r)
            PH_DECODE: begin // RQ5
                // Offers while busy are never seen, as only this phase looks
                if (instr_valid) begin
                    ir_nxt    = instr;
                    act_nxt   = 1'b1;
                    phase_nxt = PH_READ;
                end
            end
            PH_READ: begin // RQ5
                phase_nxt = PH_PROCESS;
            end
            PH_PROCESS: begin // RQ5
                phase_nxt = PH_WRITE;
            end
            PH_WRITE: begin // RQ5
                act_nxt   = 1'b0;
                phase_nxt = PH_DECODE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            phase_r <= PH_DECODE;
            ir_r    <= '0;
            act_r   <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            ir_r    <= ir_nxt;
            act_r   <= act_nxt;
        end
    end

    // Memory strobes are single-cycle pulses; address is zero when idle
    always_comb begin
        req_nxt = '0;
        if (phase_r == PH_READ && is_reg) begin
            req_nxt.rd   = 1'b1; // RQ5
            req_nxt.addr = ea;
        end
        if (phase_r == PH_WRITE && is_reg && to_reg) begin
            req_nxt.wr    = 1'b1; // RQ2
            req_nxt.addr  = ea;
            req_nxt.wdata = res;
        end
    end

    // Memory request register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            req_r <= '0;
        end else begin
            req_r <= req_nxt;
        end
    end

    // Operand latch, accumulator and flags
    always_comb begin
        opnd_nxt = opnd_r;
        acc_nxt  = acc_r;
        flg_nxt  = flg_r;
        // Read data is latched so the memory need hold it for one cycle only
        if (phase_r == PH_PROCESS) begin
            opnd_nxt = mem_rdata; // RQ5
        end
        if (phase_r == PH_WRITE && is_reg) begin
            flg_nxt = sub_flags; // RQ7
            if (!to_reg) begin
                acc_nxt = res; // RQ2
            end
        end
    end

    // Data registers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            opnd_r <= '0;
            acc_r  <= '0;
            flg_r  <= '0;
        end else begin
            opnd_r <= opnd_nxt;
            acc_r  <= acc_nxt;
            flg_r  <= flg_nxt;
        end
    end

    // Pointer subtract; flags are deliberately left untouched
    always_comb begin
        for (int i = 0; i < PTR_NUM; i++) begin
            ptr_nxt[i] = ptr_r[i];
        end
        if (phase_r == PH_WRITE && is_ptr && ptr_ok) begin
            ptr_nxt[psel] = ptr_r[psel] - {{(PTR_W-LIT_W){1'b0}}, lit}; // RQ6
        end
    end

    // Pointer registers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            for (int i = 0; i < PTR_NUM; i++) begin
                ptr_r[i] <= '0;
            end
        end else begin
            for (int i = 0; i < PTR_NUM; i++) begin
                ptr_r[i] <= ptr_nxt[i];
            end
        end
    end

    // Outputs straight from flip-flops
    assign mem_req                  = req_r;
    assign accumulator              = acc_r;
    assign flags                    = flg_r;
    assign indirect_address_pointer = {ptr_r[2], ptr_r[1], ptr_r[0]};
    assign busy                     = act_r; // Busy spans read to write

endmodule
`default_nettype wire

// File: hdl/sidp_pkg.sv
// Constants and types for the subtract instruction datapath.
// Assumes a core that presents one decoded instruction word per four-phase cycle.
//
// Notes on behaviour
// RQ1: Register subtract computes addressed register minus accumulator, two's complement.
// RQ2: Destination bit 0 writes accumulator; 1 writes back to the register.
// RQ3: Access bit 0 selects fast access bank; 1 uses bank select register.
// RQ4: Extended set, access 0, address at most 95 gives indexed literal offset mode.
// RQ5: Register subtract takes one cycle: decode, read, process, write.
// RQ6: Pointer subtract takes 6-bit literal from pointer 0..2; flags stay unchanged.
// RQ7: Register subtract sets negative, overflow, carry (no borrow), digit carry, zero flags.
package sidp_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 12;
    localparam int PTR_W  = 12;
    localparam int BANK_W = 4;

    // Field widths inside the instruction word and pointer count
    localparam int INSTR_W = 16;
    localparam int FILE_W  = 8;
    localparam int LIT_W   = 6;
    localparam int NIB_W   = 4;
    localparam int PTR_NUM = 3;

    // Opcode fields of the register subtract
    localparam logic [5:0] SUBREG_OP   = 6'h17;
    localparam int         SUBREG_MSB  = 15;
    localparam int         SUBREG_LSB  = 10;
    localparam int         DEST_BIT    = 9;
    localparam int         ACCESS_BIT  = 8;
    // Opcode fields of the pointer subtract
    localparam logic [7:0] SUBPTR_OP   = 8'hE9;
    localparam int         SUBPTR_MSB  = 15;
    localparam int         SUBPTR_LSB  = 8;
    localparam int         PSEL_MSB    = 7;
    localparam int         PSEL_LSB    = 6;
    localparam logic [1:0] PSEL_MAX    = 2'h2;

    // Addressing limits
    localparam logic [7:0] INDEXED_MAX   = 8'h5F;
    localparam logic [7:0] ACCESS_SPLIT  = 8'h80;
    localparam logic [3:0] ACCESS_HIBANK = 4'hF;
    localparam int         PTR_INDEXED   = 2;

    // Four phases of one instruction cycle
    typedef enum logic [1:0] {
        PH_DECODE,
        PH_READ,
        PH_PROCESS,
        PH_WRITE
    } sidp_phase_t;

    // Status flags
    typedef struct packed {
        logic negative;
        logic overflow_flag;
        logic zero;
        logic digit_carry_flag;
        logic carry;
    } sidp_flags_t;

    // Data-memory request towards the register file
    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } sidp_mem_req_t;

endpackage

// File: test/sidp_properties.sv
// Port checker for the subtract datapath.
// Assumes take, three busy cycles, results landing as busy falls.
`timescale 1ns/1ps
`default_nettype none
module sidp_checker
    import sidp_pkg::*;
(
    // Clock and reset
    input wire logic                core_clk,
    input wire logic                reset,
    // Observed ports
    input wire logic                instr_valid,
    input wire sidp_mem_req_t       mem_req,
    input wire logic [DATA_W-1:0]   mem_rdata,
    input wire logic [DATA_W-1:0]   accumulator,
    input wire sidp_flags_t         flags,
    input wire logic [3*PTR_W-1:0]  indirect_address_pointer,
    input wire logic                busy
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    // Cycle shape; the reset guard avoids stale sampled values after release
    take_starts_busy_a: assert property (instr_valid && !busy |=> busy)
        else $error("instruction not taken");
    busy_three_a: assert property ($rose(busy) |-> busy[*3] ##1 !busy)
        else $error("busy length wrong");
    read_in_busy_a: assert property (mem_req.rd |-> busy && $past(busy))
        else $error("read outside read phase");
    strobe_pulse_a: assert property (mem_req.rd || mem_req.wr |=> !mem_req.rd && !mem_req.wr)
        else $error("strobe held too long");
    write_slot_a: assert property (mem_req.wr |-> $past(mem_req.rd, 2) && $fell(busy))
        else $error("write out of place");
    write_diff_a: assert property (mem_req.wr |-> mem_req.wdata == $past(mem_rdata) - accumulator)
        else $error("written difference wrong");
    flags_hold_a: assert property (!$past(reset) && !$stable(flags) |-> $past(mem_req.rd, 2))
        else $error("flags moved without subtract");
    acc_update_a: assert property (!$past(reset) && !$stable(accumulator) |-> $past(mem_req.rd, 2) && !mem_req.wr)
        else $error("accumulator moved wrongly");
    ptr_update_a: assert property (!$past(reset) && !$stable(indirect_address_pointer) |-> $fell(busy))
        else $error("pointer moved out of place");
    cover property (mem_req.wr);
    cover property ($fell(busy) && !$stable(accumulator));
    cover property (!$stable(indirect_address_pointer));
endmodule

bind sidp_datapath sidp_checker chk_i (.core_clk, .reset, .instr_valid, .mem_req, .mem_rdata,
    .accumulator, .flags, .indirect_address_pointer, .busy);
`default_nettype wire

// File: test/testbench.sv
// Random instruction bench for the subtract datapath, checked against a model.
// Assumes four cycles per instruction and read data wanted during the read pulse.
`timescale 1ns/1ps
`default_nettype none
module testbench import sidp_pkg::*;;
    logic                core_clk = 1'b0;
    logic                reset = 1'b1;
    logic                instr_valid = 1'b0;
    logic [15:0]         instr = 16'h0000;
    logic                ext_set_en = 1'b0;
    logic [BANK_W-1:0]   bank_select_register = 4'h0;
    sidp_mem_req_t       mem_req;
    logic [DATA_W-1:0]   mem_rdata = 8'h00;
    logic [DATA_W-1:0]   accumulator;
    sidp_flags_t         flags;
    logic [3*PTR_W-1:0]  indirect_address_pointer;
    logic                busy;
    logic [15:0]         op;
    logic [4:0]          fl = 5'h00;
    logic [11:0]         ea;
    int                  mismatches = 0;
    int                  checks_done = 0;
    int                  seed = 32'h6e3118fb;
    int                  w = 0;
    int                  r;
    int                  res;
    int                  p[3] = '{0, 0, 0};

    always #10 core_clk = ~core_clk;

    sidp_datapath dut (.core_clk, .reset, .instr_valid, .instr, .ext_set_en,
        .bank_select_register, .mem_req, .mem_rdata, .accumulator, .flags,
        .indirect_address_pointer, .busy);

    task automatic chk(input string nm, input logic [35:0] got, input logic [35:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // One instruction; junk offered while busy must be refused
    task automatic run(input logic [15:0] o);
        instr = o;
        instr_valid = 1'b1;
        ext_set_en = 1'($random(seed));
        bank_select_register = 4'($random(seed));
        @(negedge core_clk);
        instr_valid = 1'($random(seed));
        instr = 16'($random(seed));
        @(negedge core_clk);
        r = $random(seed) & 255;
        mem_rdata = r[7:0];
        if (o[ACCESS_BIT]) ea = {bank_select_register, o[7:0]};
        else if (ext_set_en && o[7:0] <= INDEXED_MAX) ea = 12'(p[2] + o[7:0]);
        else ea = {o[7] ? 4'hF : 4'h0, o[7:0]};
        chk("busy", busy, 1'b1);
        if (o[15:10] == SUBREG_OP) chk("read", {mem_req.rd, mem_req.addr}, {1'b1, ea});
        else chk("read", mem_req.rd, 1'b0);
        repeat (2) @(negedge core_clk);
        chk("busy", busy, 1'b0);
        chk("wr", mem_req.wr, o[15:10] == SUBREG_OP && o[DEST_BIT]);
        if (o[15:10] == SUBREG_OP) begin
            res = (r - w) & 255;
            fl = {res[7], r[7] != w[7] && res[7] != r[7], res == 0, (r & 15) >= (w & 15), r >= w};
            if (o[DEST_BIT]) chk("write", {mem_req.addr, mem_req.wdata}, {ea, res[7:0]});
            else w = res;
        end else if (o[15:8] == SUBPTR_OP && o[7:6] != 2'h3) begin
            p[o[7:6]] = (p[o[7:6]] - o[5:0]) & 4095;
        end
        chk("flags", flags, fl);
        chk("acc", accumulator, w[7:0]);
        chk("ptr", indirect_address_pointer, {p[2][11:0], p[1][11:0], p[0][11:0]});
    endtask

    // Main sequence: mixed subtracts and stray opcodes, back to back
    initial begin
        repeat (12) @(negedge core_clk);
        reset = 1'b0;
        for (int i = 0; i < 300; i++) begin
            op = 16'($random(seed));
            if (i % 3 == 0) op[15:10] = SUBREG_OP;
            if (i % 3 == 1) op[15:8] = SUBPTR_OP;
            run(op);
        end
        end_sim;
    end

    // Watchdog well past the expected run
    initial begin
        #40000;
        mismatches++;
        end_sim;
    end
endmodule
`default_nettype wire
